// File: hdl/edrc_ctrl.v
// Notes on behaviour
// - Right key when locked: timed release, green 2 Hz
// - Unopened released door relocks on expiry
// - Opened door monitored; overrun starts pre-alarm
// - Door closed in monitoring: lock, red on
// - Pre-alarm: tone, green+yellow, green, dark
// - Pre-alarm expiry raises full alarm
// - Door closed in pre-alarm: lock
// - Perm end, timed release, still open: pre-alarm
// - Danger alarms served during any timing
// - Left key: permanent release, green steady
// - Lock only closed and alarm-free; red on
// - Own release blocks associated interlocked doors
// - Interlock: drive block output, honour block input
// - Central release overrides interlock, raises alarm
// - Interlock relays: interlocked, closed-locked inverse
// - Two switches choose the I/O profile
`include "edrc_consts.vh"

module edrc_ctrl #(
  parameter integer TICK_CYC = `EDRC_TICK_MS * `EDRC_CLK_KHZ
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rstn,
  // Register port
  input  wire [7:0] addr,
  input  wire [31:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [31:0] rdata,
  output reg        irq,
  // Key switch and door contact
  input  wire       key_right,
  input  wire       key_left,
  input  wire       door_closed,
  // Alarm and command inputs
  input  wire       emergency_button,
  input  wire       fire_alarm_input_inv,
  input  wire       intrusion_interlock_input,
  input  wire       lock_command_input,
  input  wire       unlock_command_input,
  input  wire       short_release_input,
  input  wire       central_release_input,
  // Profile select switches
  input  wire [1:0] profile_sel,
  // Lock and indicators
  output reg        lock_release,
  output reg  [3:0] led_green,
  output reg  [3:0] led_yellow,
  output reg  [3:0] led_red,
  output reg        buzzer,
  // Relays and interlock
  output reg        relay_out_one,
  output reg        relay_out_two,
  output reg        block_interlock_output
);

  localparam [2:0] S_LOCK = 3'h0;
  localparam [2:0] S_TREL = 3'h1;
  localparam [2:0] S_MON  = 3'h2;
  localparam [2:0] S_PRE  = 3'h3;
  localparam [2:0] S_ALM  = 3'h4;
  localparam [2:0] S_PERM = 3'h5;

  localparam integer BLINK_T = 1000 / (2 * `EDRC_BLINK_HZ) / `EDRC_TICK_MS;
  localparam integer PGY_T   = `EDRC_PRE_GY_MS / `EDRC_TICK_MS;
  localparam integer PG_T    = PGY_T + `EDRC_PRE_G_MS / `EDRC_TICK_MS;
  localparam integer PALL_T  = PG_T + `EDRC_PRE_OFF_MS / `EDRC_TICK_MS;

  function [3:0] all4;
    input on;
    begin
      all4 = {4{on}};
    end
  endfunction

  // Pin synchronisers
  localparam integer NIN = 12;
  wire [NIN-1:0] pin_raw = {profile_sel, central_release_input,
                            short_release_input, unlock_command_input,
                            lock_command_input, intrusion_interlock_input,
                            fire_alarm_input_inv, emergency_button,
                            door_closed, key_left, key_right};
  reg  [NIN-1:0] sync1_q;
  reg  [NIN-1:0] sync2_q;
  reg  [NIN-1:0] prev_q;
  // Fire input idles high; zero here would fake a danger alarm at reset
  localparam [NIN-1:0] PIN_IDLE = 12'h010;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= PIN_IDLE;
      sync2_q <= PIN_IDLE;
      prev_q  <= PIN_IDLE;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  wire [NIN-1:0] rise = sync2_q & ~prev_q;
  wire       closed_s  = sync2_q[2];
  wire       emerg_s   = sync2_q[3];
  wire       fire_n_s  = sync2_q[4];
  wire       block_s   = sync2_q[5];
  wire       central_s = sync2_q[9];
  wire [1:0] prof_s    = sync2_q[11:10];

  wire tick;
  edrc_tick #(.DIV(TICK_CYC)) u_tick (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick)
  );

  // Registers
  reg [15:0] t_rel_q;
  reg [15:0] t_mon_q;
  reg [15:0] t_pre_q;
  reg [4:0]  irq_stat_q;
  reg [4:0]  irq_mask_q;

  // Control state
  reg [2:0]  state_q;
  reg [2:0]  state_d;
  reg        from_perm_q;
  reg        from_perm_d;
  reg [15:0] tmr_q;
  reg [15:0] tmr_d;
  reg [3:0]  blink_cnt_q;
  reg        blink_q;
  reg [3:0]  phase_q;
  reg        danger_q;
  reg        refused;

  wire ilock   = (prof_s == `EDRC_PROF_ILOCK);
  wire central = ilock & central_s;
  wire danger  = emerg_s | ~fire_n_s | central;
  wire blocked = ilock & block_s & ~central;
  wire rel_req  = rise[0] | (~ilock & rise[8]);
  wire perm_req = rise[1] | (~ilock & rise[7]);
  wire lock_req = rise[0] | (~ilock & rise[6]);
  wire expire   = tick & (tmr_q == 16'h0);
  wire lock_ok  = closed_s & ~danger;

  always @* begin
    state_d     = state_q;
    from_perm_d = from_perm_q;
    refused     = 1'b0;
    case (state_q)
      S_LOCK: begin
        if ((perm_req | rel_req) & blocked) begin
          refused = 1'b1;
        end else if (perm_req) begin
          state_d = S_PERM;
        end else if (rel_req) begin
          state_d     = S_TREL;
          from_perm_d = 1'b0;
        end
      end
      S_TREL: begin
        if (~closed_s & ~from_perm_q) begin
          state_d = S_MON;
        end else if (expire) begin
          state_d = closed_s ? S_LOCK : S_PRE;
        end
      end
      S_MON: begin
        if (closed_s) begin
          state_d = S_LOCK;
        end else if (expire) begin
          state_d = S_PRE;
        end
      end
      S_PRE: begin
        if (closed_s) begin
          state_d = S_LOCK;
        end else if (expire) begin
          state_d = S_ALM;
        end
      end
      S_ALM: begin
        if (lock_req & lock_ok) begin
          state_d = S_LOCK;
        end else if (perm_req) begin
          state_d = S_PERM;
        end
      end
      S_PERM: begin
        if (lock_req) begin
          if (lock_ok) begin
            state_d = S_LOCK;
          end else begin
            state_d     = S_TREL;
            from_perm_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = S_LOCK;
      end
    endcase
  end

  // Interval timer, reloaded on every state change
  always @* begin
    tmr_d = tmr_q;
    if (state_d != state_q) begin
      case (state_d)
        S_TREL:  tmr_d = t_rel_q;
        S_MON:   tmr_d = t_mon_q;
        S_PRE:   tmr_d = t_pre_q;
        default: tmr_d = 16'h0;
      endcase
    end else if (tick && tmr_q != 16'h0) begin
      tmr_d = tmr_q - 16'h1;
    end
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= S_LOCK;
      from_perm_q <= 1'b0;
      tmr_q       <= 16'h0;
      danger_q    <= 1'b0;
    end else begin
      state_q     <= state_d;
      from_perm_q <= from_perm_d;
      tmr_q       <= tmr_d;
      danger_q    <= danger;
    end
  end

  // Blink and pre-alarm pattern phase
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blink_cnt_q <= 4'h0;
      blink_q     <= 1'b0;
      phase_q     <= 4'h0;
    end else begin
      if (tick) begin
        if (blink_cnt_q == BLINK_T - 1) begin
          blink_cnt_q <= 4'h0;
          blink_q     <= ~blink_q;
        end else begin
          blink_cnt_q <= blink_cnt_q + 4'h1;
        end
      end
      // Restart at entry so the first burst is full length
      if (state_q != S_PRE) begin
        phase_q <= 4'h0;
      end else if (tick) begin
        if (phase_q == PALL_T - 1) begin
          phase_q <= 4'h0;
        end else begin
          phase_q <= phase_q + 4'h1;
        end
      end
    end
  end

  wire pre_gy = (phase_q < PGY_T);
  wire pre_g  = (phase_q < PG_T);

  // Indicator, lock and relay outputs
  reg       rel_d;
  reg [3:0] grn_d;
  reg [3:0] yel_d;
  reg [3:0] red_d;
  reg       buz_d;
  reg       k1_d;
  reg       k2_d;

  always @* begin
    rel_d = (state_q != S_LOCK) | danger;
    grn_d = 4'h0;
    yel_d = 4'h0;
    red_d = 4'h0;
    buz_d = 1'b0;
    case (state_q)
      S_LOCK: red_d = all4(1'b1);
      S_TREL: grn_d = all4(blink_q);
      S_MON:  grn_d = all4(blink_q);
      S_PRE: begin
        grn_d = all4(pre_g);
        yel_d = all4(pre_gy);
        buz_d = pre_gy;
      end
      S_ALM: begin
        yel_d = all4(1'b1);
        buz_d = 1'b1;
      end
      S_PERM: grn_d = all4(1'b1);
      default: grn_d = 4'h0;
    endcase
    if (danger) begin
      // Danger display wins over any timing pattern
      grn_d = all4(1'b1);
      yel_d = all4(blink_q);
      red_d = 4'h0;
      buz_d = 1'b1;
    end
    case (prof_s)
      `EDRC_PROF_DRIVE: begin
        k1_d = (state_q == S_PERM);
        k2_d = rel_d;
      end
      `EDRC_PROF_DOOR: begin
        k1_d = rel_d;
        k2_d = ~rel_d;
      end
      `EDRC_PROF_ILOCK: begin
        k1_d = blocked & ~rel_d;
        k2_d = ~(closed_s & ~rel_d);
      end
      default: begin
        k1_d = rel_d;
        k2_d = ~(danger | (state_q == S_ALM));
      end
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_release           <= 1'b0;
      led_green              <= 4'h0;
      led_yellow             <= 4'h0;
      led_red                <= 4'h0;
      buzzer                 <= 1'b0;
      relay_out_one          <= 1'b0;
      relay_out_two          <= 1'b0;
      block_interlock_output <= 1'b0;
    end else begin
      lock_release           <= rel_d;
      led_green              <= grn_d;
      led_yellow             <= yel_d;
      led_red                <= red_d;
      buzzer                 <= buz_d;
      relay_out_one          <= k1_d;
      relay_out_two          <= k2_d;
      block_interlock_output <= ilock & rel_d;
    end
  end

  // Interrupt events
  wire [4:0] ev;
  assign ev[`EDRC_IRQ_ALARM]   = (state_d == S_ALM) & (state_q != S_ALM);
  assign ev[`EDRC_IRQ_PRE]     = (state_d == S_PRE) & (state_q != S_PRE);
  assign ev[`EDRC_IRQ_LOCKED]  = (state_d == S_LOCK) & (state_q != S_LOCK);
  assign ev[`EDRC_IRQ_REFUSED] = refused;
  assign ev[`EDRC_IRQ_DANGER]  = danger & ~danger_q;

  wire wr_stat = wr & (addr == `EDRC_REG_IRQ_STAT);
  wire [4:0] w1c = wr_stat ? wdata[4:0] : 5'h0;

  // Register writes; a new event wins over a clear
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t_rel_q    <= `EDRC_RST_T_REL;
      t_mon_q    <= `EDRC_RST_T_MON;
      t_pre_q    <= `EDRC_RST_T_PRE;
      irq_mask_q <= `EDRC_RST_IRQ_MASK;
      irq_stat_q <= 5'h0;
      irq        <= 1'b0;
    end else begin
      if (wr) begin
        case (addr)
          `EDRC_REG_T_REL:    t_rel_q    <= wdata[15:0];
          `EDRC_REG_T_MON:    t_mon_q    <= wdata[15:0];
          `EDRC_REG_T_PRE:    t_pre_q    <= wdata[15:0];
          `EDRC_REG_IRQ_MASK: irq_mask_q <= wdata[4:0];
          default:            irq_mask_q <= irq_mask_q;
        endcase
      end
      irq_stat_q <= (irq_stat_q & ~w1c) | ev;
      irq        <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0;
    case (addr)
      `EDRC_REG_STATUS: begin
        rd_d[`EDRC_ST_STATE_LSB +: 3] = state_q;
        rd_d[`EDRC_ST_DOOR_BIT]       = closed_s;
        rd_d[`EDRC_ST_DNG_BIT]        = danger;
        rd_d[`EDRC_ST_PROF_LSB +: 2]  = prof_s;
      end
      `EDRC_REG_T_REL:    rd_d[15:0] = t_rel_q;
      `EDRC_REG_T_MON:    rd_d[15:0] = t_mon_q;
      `EDRC_REG_T_PRE:    rd_d[15:0] = t_pre_q;
      `EDRC_REG_IRQ_STAT: rd_d[4:0]  = irq_stat_q;
      `EDRC_REG_IRQ_MASK: rd_d[4:0]  = irq_mask_q;
      default:            rd_d       = 32'h0;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0;
    end else begin
      rdata <= rd ? rd_d : 32'h0;
    end
  end

endmodule

// File: pkg/edrc_consts.vh
`ifndef EDRC_CONSTS_VH
`define EDRC_CONSTS_VH

// Clock and tick
`define EDRC_CLK_KHZ       100000
`define EDRC_TICK_MS       50

// Indicator timing
`define EDRC_BLINK_HZ      2
`define EDRC_PRE_GY_MS     200
`define EDRC_PRE_G_MS      100
`define EDRC_PRE_OFF_MS    100

// Register byte offsets
`define EDRC_REG_STATUS    8'h00
`define EDRC_REG_T_REL     8'h04
`define EDRC_REG_T_MON     8'h08
`define EDRC_REG_T_PRE     8'h0c
`define EDRC_REG_IRQ_STAT  8'h10
`define EDRC_REG_IRQ_MASK  8'h14

// Reset values, times in ticks
`define EDRC_RST_T_REL     16'h0064
`define EDRC_RST_T_MON     16'h00c8
`define EDRC_RST_T_PRE     16'h00c8
`define EDRC_RST_IRQ_MASK  5'h00

// Status fields
`define EDRC_ST_STATE_LSB  0
`define EDRC_ST_DOOR_BIT   4
`define EDRC_ST_DNG_BIT    5
`define EDRC_ST_PROF_LSB   8

// Interrupt bits
`define EDRC_IRQ_ALARM     0
`define EDRC_IRQ_PRE       1
`define EDRC_IRQ_LOCKED    2
`define EDRC_IRQ_REFUSED   3
`define EDRC_IRQ_DANGER    4

// Profiles
`define EDRC_PROF_LINK     2'h0
`define EDRC_PROF_DRIVE    2'h1
`define EDRC_PROF_DOOR     2'h2
`define EDRC_PROF_ILOCK    2'h3

`endif

// File: hdl/edrc_tick.v
module edrc_tick #(
  parameter integer DIV = 5000000
) (
  // Clock and reset
  input  wire clk,
  input  wire rstn,
  // Slow enable
  output reg  tick
);

  reg [31:0] cnt_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end else if (cnt_q == DIV - 1) begin
      cnt_q <= 32'h0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick  <= 1'b0;
    end
  end

endmodule

// File: sim/edrc_door_model.sv
module edrc_door_model (
  // Clock
  input  wire clk,
  // Lock and user
  input  wire lock_release,
  input  wire want_open,
  // Door contact
  output reg  door_closed
);
  timeunit 1ns;
  timeprecision 1ps;
  initial door_closed = 1'b1;
  // A held bolt keeps the leaf shut however hard it is pushed
  always @(posedge clk) begin
    if (want_open && lock_release)
      door_closed <= 1'b0;
    else if (!want_open)
      door_closed <= 1'b1;
  end
endmodule

// File: sim/edrc_ctrl_asserts.sv
module edrc_ctrl_chk (
  // Clock and reset
  input wire        clk,
  input wire        rstn,
  // Watched inputs
  input wire        rd,
  input wire [1:0]  profile_sel,
  input wire        emergency_button,
  input wire        fire_alarm_input_inv,
  input wire        central_release_input,
  input wire        intrusion_interlock_input,
  // Watched outputs
  input wire [31:0] rdata,
  input wire        lock_release,
  input wire [3:0]  led_green,
  input wire [3:0]  led_red,
  input wire        buzzer,
  input wire        relay_out_two,
  input wire        block_interlock_output
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  wire p3 = profile_sel == 2'h3;
  // Windows of 5 to 8 cycles cover the two-flop input lag
  wire calm = fire_alarm_input_inv && !emergency_button &&
              !(p3 && central_release_input);

  chk_rdata_idle:
    assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside its slot");
  chk_red_locked:
    assert property (led_red == 4'hf |-> !lock_release && led_green == 4'h0)
    else $error("red lit on a released door");
  chk_emerg_open:
    assert property (emergency_button [*6] |->
      lock_release && buzzer && led_red == 4'h0)
    else $error("emergency did not release");
  chk_fire_open:
    assert property (!fire_alarm_input_inv [*6] |->
      lock_release && led_green == 4'hf)
    else $error("fire alarm did not release");
  chk_central_open:
    assert property ((p3 && central_release_input) [*6] |-> lock_release)
    else $error("central release ignored");
  chk_block_rel:
    assert property (p3 [*5] |-> block_interlock_output == lock_release)
    else $error("block output does not follow release");
  chk_block_prof:
    assert property (!p3 [*5] |-> !block_interlock_output)
    else $error("block output outside interlock");
  chk_relay_two:
    assert property (p3 [*5] ##0 lock_release |-> relay_out_two)
    else $error("closed-locked relay wrong");
  chk_block_in:
    assert property ((p3 && intrusion_interlock_input && calm &&
      led_red == 4'hf) [*8] |=> !lock_release)
    else $error("blocked door released");
endmodule

bind edrc_ctrl edrc_ctrl_chk i_edrc_ctrl_chk (
  .clk, .rstn, .rd, .profile_sel, .emergency_button, .fire_alarm_input_inv,
  .central_release_input, .intrusion_interlock_input, .rdata, .lock_release,
  .led_green, .led_red, .buzzer, .relay_out_two, .block_interlock_output);

// File: sim/edrc_ctrl_tb_top.sv
`include "edrc_consts.vh"

module edrc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer TCK = 4;
  reg         clk, rstn, wr, rd, key_right, key_left, want_open;
  reg         emergency_button, fire_alarm_input_inv;
  reg         central_release_input, intrusion_interlock_input;
  reg         lock_command_input, unlock_command_input, short_release_input;
  reg  [1:0]  profile_sel;
  reg  [7:0]  addr;
  reg  [31:0] wdata, rv;
  reg  [15:0] t_rel, t_mon, t_pre;
  reg  [3:0]  last_g;
  wire [31:0] rdata;
  wire [3:0]  led_green, led_yellow, led_red;
  wire        irq, lock_release, buzzer, relay_out_one, relay_out_two;
  wire        block_interlock_output, door_closed;
  wire [3:0]  lamp = {&led_green, |led_green, &led_yellow, |led_yellow};
  integer     num_errors, check_count, n, g, gy, dk;

  edrc_ctrl #(.TICK_CYC(TCK)) i_edrc_ctrl (
    .clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .irq, .key_right,
    .key_left, .door_closed, .emergency_button, .fire_alarm_input_inv,
    .intrusion_interlock_input, .lock_command_input,
    .unlock_command_input, .short_release_input,
    .central_release_input, .profile_sel, .lock_release, .led_green,
    .led_yellow, .led_red, .buzzer, .relay_out_one, .relay_out_two,
    .block_interlock_output);

  edrc_door_model i_edrc_door_model (.clk, .lock_release, .want_open,
    .door_closed);

  // Status polls of two cycles: N+1 ticks, tick phase, margin
  function integer polls(input [15:0] t);
    polls = (t + 3) * TCK / 2 + 2;
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task idle(input integer c);
    begin
      repeat (c) @(posedge clk);
      #1;
    end
  endtask

  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask

  task rd_reg(input [7:0] a);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 rv = rdata;
    end
  endtask

  task turn(input right);
    begin
      @(posedge clk);
      key_right <= right;
      key_left <= !right;
      repeat (4) @(posedge clk);
      key_right <= 1'b0;
      key_left <= 1'b0;
      idle(6);
    end
  endtask

  task cmd(input [2:0] c);
    begin
      @(posedge clk);
      {short_release_input, unlock_command_input, lock_command_input} <= c;
      repeat (4) @(posedge clk);
      {short_release_input, unlock_command_input, lock_command_input} <= 3'h0;
      idle(6);
    end
  endtask

  task wait_state(input [2:0] s, input integer lim);
    begin
      n = 0;
      rd_reg(`EDRC_REG_STATUS);
      while (rv[2:0] !== s && n < lim) begin
        rd_reg(`EDRC_REG_STATUS);
        n = n + 1;
      end
      chk(rv[2:0], s);
    end
  endtask

  task open_mon;
    begin
      turn(1'b1);
      @(posedge clk);
      want_open <= 1'b1;
      wait_state(3'h2, 8);
    end
  endtask

  task stop_test;
    begin
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #300000;
    num_errors = num_errors + 1;
    stop_test;
  end

  initial begin
    {rstn, wr, rd, key_right, key_left, want_open} = 6'h0;
    {emergency_button, central_release_input} = 2'h0;
    {lock_command_input, unlock_command_input, short_release_input} = 3'h0;
    {intrusion_interlock_input, fire_alarm_input_inv} = 2'h1;
    {profile_sel, addr, wdata} = 42'h0;
    {num_errors, check_count} = 64'h0;
    n = $urandom(32'ha17d0b70);
    // Release must outlast the 40-cycle blink window
    t_rel = 16'(15 + $urandom % 4);
    t_mon = 16'(5 + $urandom % 3);
    t_pre = 16'(12 + $urandom % 3);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(`EDRC_REG_T_REL);
    chk(rv, {16'h0, `EDRC_RST_T_REL});
    rd_reg(8'h20);
    chk(rv, 32'h0);
    wr_reg(8'h20, 32'hffffffff);
    wr_reg(`EDRC_REG_T_REL, {16'h0, t_rel});
    wr_reg(`EDRC_REG_T_MON, {16'h0, t_mon});
    wr_reg(`EDRC_REG_T_PRE, {16'h0, t_pre});
    wr_reg(`EDRC_REG_IRQ_STAT, 32'h1f);
    for (g = 0; g < 4; g = g + 1) begin
      @(posedge clk);
      profile_sel <= g[1:0];
      idle(6);
      rd_reg(`EDRC_REG_STATUS);
      chk(rv[9:8], g);
    end
    @(posedge clk);
    profile_sel <= 2'h0;
    idle(6);
    turn(1'b1);
    chk({lock_release, |led_red}, 2'h2);
    last_g = led_green;
    dk = 0;
    repeat (40) begin
      idle(1);
      if (led_green !== last_g)
        dk = dk + 1;
      last_g = led_green;
    end
    chk(dk, 2);
    wait_state(3'h0, polls(t_rel));
    chk(led_red, 4'hf);
    chk(irq, 1'b0);
    wr_reg(`EDRC_REG_IRQ_MASK, 32'h1f);
    idle(2);
    chk(irq, 1'b1);
    wr_reg(`EDRC_REG_IRQ_STAT, 32'h1f);
    idle(2);
    chk(irq, 1'b0);
    open_mon;
    @(posedge clk);
    want_open <= 1'b0;
    wait_state(3'h0, 8);
    chk(led_red, 4'hf);
    open_mon;
    wait_state(3'h3, polls(t_mon));
    {g, gy, dk} = 96'h0;
    repeat (32) begin
      idle(1);
      if (lamp === 4'hf && buzzer === 1'b1)
        gy = gy + 1;
      if (lamp === 4'hc)
        g = g + 1;
      if (lamp === 4'h0)
        dk = dk + 1;
    end
    chk(gy, 16);
    chk(g, 8);
    chk(dk, 8);
    wait_state(3'h4, polls(t_pre));
    chk({lock_release, buzzer}, 2'h3);
    @(posedge clk);
    want_open <= 1'b0;
    idle(4);
    turn(1'b1);
    chk(led_red, 4'hf);
    turn(1'b0);
    chk({lock_release, led_green}, 5'h1f);
    @(posedge clk);
    want_open <= 1'b1;
    idle(4);
    turn(1'b1);
    wait_state(3'h1, 2);
    wait_state(3'h3, polls(t_rel));
    @(posedge clk);
    want_open <= 1'b0;
    wait_state(3'h0, 8);
    for (g = 0; g < 2; g = g + 1) begin
      @(posedge clk);
      emergency_button <= (g == 0);
      fire_alarm_input_inv <= (g == 0);
      idle(8);
      chk({lock_release, led_red}, 5'h10);
      @(posedge clk);
      emergency_button <= 1'b0;
      fire_alarm_input_inv <= 1'b1;
      idle(8);
      chk({lock_release, led_red}, 5'h0f);
    end
    // Command inputs act like the key outside the interlock profile
    cmd(3'h2);
    chk({lock_release, led_green, relay_out_one}, 6'h3f);
    cmd(3'h1);
    chk(led_red, 4'hf);
    cmd(3'h4);
    wait_state(3'h1, 2);
    wait_state(3'h0, polls(t_rel));
    @(posedge clk);
    profile_sel <= 2'h3;
    idle(6);
    turn(1'b1);
    chk({block_interlock_output, relay_out_two}, 2'h3);
    wait_state(3'h0, polls(t_rel));
    chk(relay_out_two, 1'b0);
    cmd(3'h6);
    chk(lock_release, 1'b0);
    @(posedge clk);
    intrusion_interlock_input <= 1'b1;
    idle(6);
    turn(1'b1);
    chk({lock_release, relay_out_one}, 2'h1);
    rd_reg(`EDRC_REG_IRQ_STAT);
    chk(rv[3], 1'b1);
    @(posedge clk);
    central_release_input <= 1'b1;
    idle(8);
    rd_reg(`EDRC_REG_STATUS);
    chk({lock_release, rv[5]}, 2'h3);
    @(posedge clk);
    {central_release_input, intrusion_interlock_input} <= 2'h0;
    idle(8);
    stop_test;
  end
endmodule
